/* File: verilog/rtcu_pkg.sv */
// Package with constants and types of the rotate-through-carry unit.
package rtcu_pkg;
  // ----------------------------------------------------------------
  // Instruction encoding
  // ----------------------------------------------------------------
  localparam int          INSTR_W        = 14;
  localparam int          OPC_POS        = 8;
  localparam int          DEST_POS       = 7;
  localparam logic [5:0]  OPC_RLC        = 6'h0D;
  localparam logic [5:0]  OPC_RRC        = 6'h0C;
  localparam int          ADDR_W         = 7;
  localparam int          DATA_W         = 8;
  localparam int          RF_DEPTH       = 128;
  // ----------------------------------------------------------------
  // Reset values and phases
  // ----------------------------------------------------------------
  localparam logic [7:0]  ACC_RESET      = 8'h00;
  localparam logic        CARRY_RESET    = 1'b0;
  localparam logic        ZERO_RESET     = 1'b0;
  localparam logic        DCARRY_RESET   = 1'b0;
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  localparam int          PHASE_COUNT    = 4;
  typedef enum logic [1:0] {
    RTCU_Q1 = 2'b00,
    RTCU_Q2 = 2'b01,
    RTCU_Q3 = 2'b10,
    RTCU_Q4 = 2'b11
  } rtcu_phase_type;
endpackage : rtcu_pkg

/* File: verilog/rtcu_regfile.sv */
// File register memory with registered read data.
module rtcu_regfile (
  input  wire logic       core_clk,
  input  wire logic [6:0] rd_addr,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  input  wire logic [6:0] wr_addr,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data
);
  logic [7:0] mem [0:rtcu_pkg::RF_DEPTH-1];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : rtcu_regfile

/* File: verilog/rtcu_top.sv */
// Rotate-through-carry execution unit with accumulator and file registers.
module rtcu_top (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [13:0] instr,
  input  wire logic        instr_valid,
  output logic             instr_ready,
  output logic             instr_done,
  output logic      [7:0]  acc,
  output logic             carry,
  output logic             zero_flag,
  output logic             dcarry_flag,
  output logic             illegal_op
);
  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  rtcu_pkg::rtcu_phase_type phase;
  rtcu_pkg::rtcu_phase_type next_phase;
  logic [13:0] ir;
  logic        busy;
  logic [7:0]  operand;
  logic [7:0]  result;
  logic        result_carry;
  logic [7:0]  rf_rd_data;

  wire  [5:0]  ir_opc   = ir[13:rtcu_pkg::OPC_POS];
  wire         ir_dest  = ir[rtcu_pkg::DEST_POS];
  wire  [6:0]  ir_addr  = ir[6:0];
  wire         is_left  = (ir_opc == rtcu_pkg::OPC_RLC);
  wire         is_right = (ir_opc == rtcu_pkg::OPC_RRC);
  wire         is_rot   = is_left | is_right;
  wire         start    = instr_valid & instr_ready;
  wire         in_q2    = busy & (phase == rtcu_pkg::RTCU_Q2);
  wire         in_q4    = busy & (phase == rtcu_pkg::RTCU_Q4);
  wire         write_en = in_q4 & is_rot;

  // Accepting only in Q1 keeps one instruction per four-phase cycle.
  assign instr_ready = (phase == rtcu_pkg::RTCU_Q1);

  always_comb begin
    case (phase)
      rtcu_pkg::RTCU_Q1: next_phase = start ? rtcu_pkg::RTCU_Q2 : rtcu_pkg::RTCU_Q1;
      rtcu_pkg::RTCU_Q2: next_phase = rtcu_pkg::RTCU_Q3;
      rtcu_pkg::RTCU_Q3: next_phase = rtcu_pkg::RTCU_Q4;
      rtcu_pkg::RTCU_Q4: next_phase = rtcu_pkg::RTCU_Q1;
      default:           next_phase = rtcu_pkg::RTCU_Q1;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase <= rtcu_pkg::RTCU_Q1;
      busy  <= 1'b0;
      ir    <= 14'h0000;
    end else begin
      phase <= next_phase;
      if (start) begin
        ir   <= instr;
        busy <= 1'b1;
      end else if (in_q4) begin
        busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read and rotation
  // ----------------------------------------------------------------
  rtcu_regfile u_regfile (
    .core_clk (core_clk),
    .rd_addr  (ir_addr),
    .rd_en    (in_q2),
    .rd_data  (rf_rd_data),
    .wr_addr  (ir_addr),
    .wr_en    (write_en & ir_dest),
    .wr_data  (result)
  );

  // Q3 works on the read data register itself; a second capture would lag a phase.
  assign operand = rf_rd_data;

  // The ninth ring bit is the carry flag itself.
  wire [8:0] ring_left  = {operand, carry};
  wire [8:0] ring_right = {operand[0], carry, operand[7:1]};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      result       <= rtcu_pkg::DATA_RESET;
      result_carry <= rtcu_pkg::CARRY_RESET;
    end else begin
      if (busy && phase == rtcu_pkg::RTCU_Q3) begin
        if (is_left) begin
          result       <= ring_left[7:0];
          result_carry <= ring_left[8];
        end else begin
          result       <= ring_right[7:0];
          result_carry <= ring_right[8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Write back
  // ----------------------------------------------------------------
  // Read data registers at the end of Q2, so Q3 processes the registered read data directly.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      acc         <= rtcu_pkg::ACC_RESET;
      carry       <= rtcu_pkg::CARRY_RESET;
      zero_flag   <= rtcu_pkg::ZERO_RESET;
      dcarry_flag <= rtcu_pkg::DCARRY_RESET;
      instr_done  <= 1'b0;
      illegal_op  <= 1'b0;
    end else begin
      instr_done <= in_q4;
      illegal_op <= in_q4 & ~is_rot;
      if (write_en) begin
        carry <= result_carry;
        if (!ir_dest) begin
          acc <= result;
        end
      end
      zero_flag   <= zero_flag;
      dcarry_flag <= dcarry_flag;
    end
  end
endmodule : rtcu_top

/* File: tb/rtcu_sva.sv */
// Port checker of the rotate-through-carry unit.
module rtcu_sva (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [13:0] instr,
  input wire logic        instr_valid,
  input wire logic        instr_ready,
  input wire logic        instr_done,
  input wire logic [7:0]  acc,
  input wire logic        carry,
  input wire logic        zero_flag,
  input wire logic        dcarry_flag,
  input wire logic        illegal_op
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [13:0] held;
  wire take = instr_valid && instr_ready;
  wire lft = held[13:8] == rtcu_pkg::OPC_RLC;
  wire rgt = held[13:8] == rtcu_pkg::OPC_RRC;
  always_ff @(posedge core_clk) if (take) held <= instr;
  done_delay_a: assert property (take |-> ##4 instr_done)
    else $error("done not four cycles after accept");
  busy_gap_a: assert property (take |=> !instr_ready [*3] ##1 instr_ready)
    else $error("ready gap wrong");
  flags_still_a: assert property ($stable(zero_flag) && $stable(dcarry_flag))
    else $error("zero or digit carry moved");
  acc_moves_a: assert property ($changed(acc) |-> instr_done && !illegal_op)
    else $error("acc moved outside a rotate");
  carry_moves_a: assert property ($changed(carry) |-> instr_done && !illegal_op)
    else $error("carry moved outside a rotate");
  left_fill_a: assert property (instr_done && lft && !held[7] |-> acc[0] == $past(carry))
    else $error("left rotate lsb not old carry");
  right_fill_a: assert property (instr_done && rgt && !held[7] |-> acc[7] == $past(carry))
    else $error("right rotate msb not old carry");
  dest_reg_a: assert property (instr_done && held[7] |-> $stable(acc))
    else $error("acc written with register destination");
endmodule : rtcu_sva
bind rtcu_top rtcu_sva u_sva (.core_clk, .rst_n, .instr, .instr_valid, .instr_ready,
  .instr_done, .acc, .carry, .zero_flag, .dcarry_flag, .illegal_op);

/* File: tb/rtcu_top_tb.sv */
// Self-checking bench of the rotate-through-carry unit.
module rtcu_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic        instr_valid = 1'b0;
  logic        instr_ready, instr_done, carry, zero_flag, dcarry_flag, illegal_op;
  logic [7:0]  acc, ea, mem [128];
  logic        ec;
  int          bad_count = 0;
  int          compares = 0;
  int          seed = 32'hC567;
  always #5 core_clk = ~core_clk;
  rtcu_top dut (.core_clk, .rst_n, .instr, .instr_valid, .instr_ready, .instr_done,
    .acc, .carry, .zero_flag, .dcarry_flag, .illegal_op);
  task check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function logic [8:0] rot(input logic left, input logic c, input logic [7:0] v);
    return left ? {v, c} : {v[0], c, v[7:1]};
  endfunction : rot
  task tally_and_finish;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  task run(input logic [13:0] w);
    int n;
    logic [8:0] r;
    logic isrot;
    @(posedge core_clk);
    instr <= w;
    instr_valid <= 1'b1;
    n = 0;
    do begin @(negedge core_clk); n++; end while (instr_ready !== 1'b1 && n < 9);
    // A unit that never becomes ready ends the run rather than stalling the bench.
    if (instr_ready !== 1'b1) begin bad_count++; tally_and_finish(); end
    @(posedge core_clk);
    instr_valid <= 1'b0;
    n = 0;
    do begin @(negedge core_clk); n++; end while (instr_done !== 1'b1 && n < 9);
    // A hung unit ends the run here rather than stalling the whole bench.
    if (instr_done !== 1'b1) begin bad_count++; tally_and_finish(); end
    isrot = (w[13:8] == rtcu_pkg::OPC_RLC) || (w[13:8] == rtcu_pkg::OPC_RRC);
    r = rot(w[13:8] == rtcu_pkg::OPC_RLC, ec, mem[w[6:0]]);
    if (isrot) begin ec = r[8]; if (w[7]) mem[w[6:0]] = r[7:0]; else ea = r[7:0]; end
    check("cycles", 9'(n), 9'(rtcu_pkg::PHASE_COUNT));
    check("acc", {1'b0, acc}, {1'b0, ea});
    check("carry", {8'h00, carry}, {8'h00, ec});
    check("reg", {1'b0, dut.u_regfile.mem[w[6:0]]}, {1'b0, mem[w[6:0]]});
    check("flags", {6'h00, zero_flag, dcarry_flag, illegal_op}, {8'h00, !isrot});
  endtask : run
  initial begin
    logic [13:0] w;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    ec = 1'b0;
    ea = 8'h00;
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'($random(seed));
      dut.u_regfile.mem[i] = mem[i];
    end
    run({rtcu_pkg::OPC_RLC, 8'hFF});
    run({rtcu_pkg::OPC_RRC, 8'h7F});
    for (int i = 0; i < 80; i++) begin
      w = 14'($random(seed));
      if (w[9]) w[13:9] = 5'h06;
      if (w[10]) w[6:2] = 5'h00;
      run(w);
    end
    tally_and_finish();
  end
endmodule : rtcu_top_tb
